// >>> rtl/vrs_sequencer.sv
// reference sequencer with filtering, stepping, power-good and faults
//
// Functional notes
// - identification inputs read zero when grounded, one when floating
// - reference from 5-bit code, 0.800V to 1.550V in 25mV steps
// - all-ones code latches shutdown: drives off, protections off
// - code sampled once per switching cycle
// - new code taken only after stable more than one cycle
// - reference steps one 25mV step per cycle to target
// - code changes ignored while stepping, monitoring resumes after
// - power-good masked while stepping; over/under-voltage stay active
// - window and fault thresholds follow programmed code
// - power-good pulled low when output lies outside window
// - inhibit pin level below threshold stops operation
// - over/under-voltage forces fault pin high, latched until srst
// - over-voltage stops regulation and turns on low-side drives
// - two phases run half a period apart
// - switching clock defaults to 200kHz
module vrs_sequencer #(
   parameter int unsigned SW_DIV = vrs_pkg::VRS_SW_DIV
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // identification pins, already pulled up externally
   input  wire logic [4:0]          voltage_id_inputs,
   // output voltage sense from converter, in mV
   input  wire logic [11:0]         sense_mv,
   // shared oscillator/inhibit/fault pin (oe low = drive)
   input  wire logic                osc_inhibit_fault_pin_i,
   output logic                     osc_inhibit_fault_pin_o,
   output logic                     osc_inhibit_fault_pin_oe_n,
   // power-good open collector (oe low = drive low)
   output logic                     power_good_output_o,
   output logic                     power_good_output_oe_n,
   // references and drives
   output logic [4:0]               programmed_reference,
   output vrs_pkg::vrs_gate_t       gate,
   output logic                     phase1_low_side_drive,
   output logic                     phase2_low_side_drive,
   output logic                     no_load_shutdown_mode,
   output logic                     irq
);
   // ==========================================================
   // switching clock divider
   logic [$clog2(SW_DIV)-1:0] div_q;
   logic                      sw_tick;
   logic                      half_tick;
   always_ff @(posedge clk) begin
      if (srst || div_q == ($clog2(SW_DIV))'(SW_DIV - 1)) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign sw_tick   = (div_q == '0);
   assign half_tick = (div_q == ($clog2(SW_DIV))'(SW_DIV / 2));

   // ==========================================================
   // pin synchronisers: three stages, change taken when 2 and 3 agree
   logic [4:0] vid_s1_q, vid_s2_q, vid_s3_q, vid_q;
   logic [2:0] inh_s_q;
   logic       inh_q;
   // pins read as level, pull-up makes floating a one
   always_ff @(posedge clk) begin
      if (srst) begin
         vid_s1_q <= vrs_pkg::VRS_CODE_RST;
         vid_s2_q <= vrs_pkg::VRS_CODE_RST;
         vid_s3_q <= vrs_pkg::VRS_CODE_RST;
         vid_q    <= vrs_pkg::VRS_CODE_RST;
         inh_s_q  <= 3'h7;
         inh_q    <= 1'b1;
      end else begin
         vid_s1_q <= voltage_id_inputs;
         vid_s2_q <= vid_s1_q;
         vid_s3_q <= vid_s2_q;
         if (vid_s2_q == vid_s3_q) begin
            vid_q <= vid_s3_q;
         end
         inh_s_q <= {inh_s_q[1:0], osc_inhibit_fault_pin_i};
         if (inh_s_q[1] == inh_s_q[2]) begin
            inh_q <= inh_s_q[2];
         end
      end
   end

   // ==========================================================
   // registers visible to software
   logic [31:0] ctrl_q;
   logic [4:0]  irq_st_q, irq_en_q, irq_set;
   logic        run_en;
   assign run_en = ctrl_q[0];

   // ==========================================================
   // sequencer state
   vrs_pkg::vrs_state_t st_q;
   logic [4:0] samp_q;       // last sample taken at a tick
   logic [1:0] stab_q;       // ticks the sample has held
   logic [4:0] tgt_q;
   logic [4:0] ref_q;
   logic       started_q;    // first code taken directly at start
   logic       fault_q;
   logic       ov_q;
   logic       inhibit;
   logic       ov_now, uv_now, pg_in;
   logic [11:0] ref_mv;

   // pin held low means inhibit; fault overrides own drive
   assign inhibit = !inh_q && !fault_q;

   // sample once per cycle, count stable repeats
   always_ff @(posedge clk) begin
      if (srst) begin
         samp_q <= vrs_pkg::VRS_CODE_RST;
         stab_q <= '0;
      end else if (sw_tick) begin
         samp_q <= vid_q;
         if (vid_q != samp_q) begin
            stab_q <= '0;
         end else if (stab_q != vrs_pkg::VRS_STABLE_CNT) begin
            stab_q <= stab_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q      <= vrs_pkg::VRS_ST_RUN;
         tgt_q     <= vrs_pkg::VRS_CODE_RST;
         ref_q     <= vrs_pkg::VRS_CODE_RST;
         started_q <= 1'b0;
         fault_q   <= 1'b0;
         ov_q      <= 1'b0;
      end else if (sw_tick && !inhibit && run_en) begin
         unique case (st_q)
            vrs_pkg::VRS_ST_RUN: begin
               if (started_q && (ov_now || uv_now)) begin
                  st_q    <= vrs_pkg::VRS_ST_FLT;
                  fault_q <= 1'b1;
                  ov_q    <= ov_now;
               end else if (stab_q == vrs_pkg::VRS_STABLE_CNT &&
                            samp_q == vrs_pkg::VRS_CODE_OFF) begin
                  st_q <= vrs_pkg::VRS_ST_OFF;
               end else if (stab_q == vrs_pkg::VRS_STABLE_CNT &&
                            !started_q) begin
                  ref_q     <= samp_q;
                  tgt_q     <= samp_q;
                  started_q <= 1'b1;
               end else if (stab_q == vrs_pkg::VRS_STABLE_CNT &&
                            samp_q != ref_q) begin
                  tgt_q <= samp_q;
                  st_q  <= vrs_pkg::VRS_ST_STEP;
               end
            end
            vrs_pkg::VRS_ST_STEP: begin
               if (ov_now || uv_now) begin
                  st_q    <= vrs_pkg::VRS_ST_FLT;
                  fault_q <= 1'b1;
                  ov_q    <= ov_now;
               end else if (ref_q < tgt_q) begin
                  ref_q <= ref_q + 1'b1;
                  if (ref_q + 1'b1 == tgt_q) st_q <= vrs_pkg::VRS_ST_RUN;
               end else if (ref_q > tgt_q) begin
                  ref_q <= ref_q - 1'b1;
                  if (ref_q - 1'b1 == tgt_q) st_q <= vrs_pkg::VRS_ST_RUN;
               end else begin
                  st_q <= vrs_pkg::VRS_ST_RUN;
               end
            end
            vrs_pkg::VRS_ST_OFF: st_q <= vrs_pkg::VRS_ST_OFF;
            vrs_pkg::VRS_ST_FLT: st_q <= vrs_pkg::VRS_ST_FLT;
         endcase
      end
   end

   assign ref_mv = vrs_pkg::vrs_code_mv(ref_q);
   assign ov_now = sense_mv > ref_mv + 12'(vrs_pkg::VRS_OV_MARGIN);
   assign uv_now = sense_mv + 12'(vrs_pkg::VRS_UV_MARGIN) < ref_mv;
   assign pg_in  = (sense_mv <= ref_mv + 12'(vrs_pkg::VRS_PG_MARGIN)) &&
                   (sense_mv + 12'(vrs_pkg::VRS_PG_MARGIN) >= ref_mv);

   // ==========================================================
   // outputs: gates, power-good, fault pin
   logic       active;
   logic       pg_q;
   logic       ph1_q, ph2_q;
   vrs_pkg::vrs_gate_t gate_q;
   assign active = started_q && run_en && !inhibit &&
                   st_q inside {vrs_pkg::VRS_ST_RUN, vrs_pkg::VRS_ST_STEP};

   // phase 2 turns on half a period after phase 1
   always_ff @(posedge clk) begin
      if (srst) begin
         ph1_q <= 1'b0;
         ph2_q <= 1'b0;
      end else begin
         if (sw_tick)   ph1_q <= 1'b1;
         if (half_tick) ph1_q <= 1'b0;
         if (half_tick) ph2_q <= 1'b1;
         if (sw_tick)   ph2_q <= 1'b0;
      end
   end

   // over-voltage crowbar; and inhibit turn all off
   always_ff @(posedge clk) begin
      if (srst) begin
         gate_q <= '0;
         pg_q   <= 1'b0;
      end else begin
         if (fault_q && ov_q) begin
            gate_q <= '{hs1: 1'b0, ls1: 1'b1, hs2: 1'b0, ls2: 1'b1};
         end else if (active) begin
            gate_q <= '{hs1: ph1_q, ls1: !ph1_q, hs2: ph2_q, ls2: !ph2_q};
         end else begin
            gate_q <= '0;
         end
         // masked while stepping, low outside window
         pg_q <= active && st_q == vrs_pkg::VRS_ST_RUN && pg_in;
      end
   end

   assign gate                  = gate_q;
   assign phase1_low_side_drive = gate_q.ls1;
   assign phase2_low_side_drive = gate_q.ls2;
   assign programmed_reference  = ref_q;
   assign no_load_shutdown_mode = (st_q == vrs_pkg::VRS_ST_OFF);
   // open collector: drive low unless good
   assign power_good_output_o    = 1'b0;
   assign power_good_output_oe_n = pg_q;
   // fault pin driven high while latched
   assign osc_inhibit_fault_pin_o    = 1'b1;
   assign osc_inhibit_fault_pin_oe_n = !fault_q;

   // ==========================================================
   // interrupt events
   logic st_step_prev_q, inh_prev_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         st_step_prev_q <= 1'b0;
         inh_prev_q     <= 1'b0;
      end else begin
         st_step_prev_q <= (st_q == vrs_pkg::VRS_ST_STEP);
         inh_prev_q     <= inhibit;
      end
   end
   always_comb begin
      irq_set = '0;
      irq_set[vrs_pkg::VRS_IRQ_DONE] = st_step_prev_q &&
                                       st_q == vrs_pkg::VRS_ST_RUN;
      irq_set[vrs_pkg::VRS_IRQ_OV]  = fault_q && ov_q;
      irq_set[vrs_pkg::VRS_IRQ_UV]  = fault_q && !ov_q;
      irq_set[vrs_pkg::VRS_IRQ_OFF] = no_load_shutdown_mode;
      irq_set[vrs_pkg::VRS_IRQ_INH] = inhibit && !inh_prev_q;
   end

   // ==========================================================
   // apb slave, zero wait states
   logic wr_en, rd_en;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // control, enable and sticky status; set wins over clear
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q   <= vrs_pkg::VRS_CTRL_RST;
         irq_en_q <= '0;
         irq_st_q <= '0;
      end else begin
         if (wr_en && paddr == vrs_pkg::VRS_OFF_CTRL) ctrl_q <= pwdata;
         if (wr_en && paddr == vrs_pkg::VRS_OFF_IRQ_EN)
            irq_en_q <= pwdata[4:0];
         if (wr_en && paddr == vrs_pkg::VRS_OFF_IRQ_CLR)
            irq_st_q <= (irq_st_q & ~pwdata[4:0]) | irq_set;
         else
            irq_st_q <= irq_st_q | irq_set;
      end
   end

   // read data registered during setup, valid in access phase
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= '0;
      end else if (rd_en && !penable) begin
         unique case (paddr)
            vrs_pkg::VRS_OFF_CTRL:   prdata <= {31'h0, ctrl_q[0]};
            vrs_pkg::VRS_OFF_STAT:   prdata <= {16'h0, st_q, tgt_q,
                                                 ref_q, pg_q, fault_q};
            vrs_pkg::VRS_OFF_IRQ_ST: prdata <= {27'h0, irq_st_q};
            vrs_pkg::VRS_OFF_IRQ_EN: prdata <= {27'h0, irq_en_q};
            vrs_pkg::VRS_OFF_SENSE:  prdata <= {20'h0, sense_mv};
            default:                 prdata <= '0;
         endcase
      end
   end

   assign irq = |(irq_st_q & irq_en_q);

   // ==========================================================
   // assertions
   // once started, reference moves at most one step per cycle
   a_ref_one_step: assert property (@(posedge clk) disable iff (srst)
      $changed(ref_q) && $past(started_q) |->
         (ref_q == $past(ref_q) + 5'h01 || ref_q == $past(ref_q) - 5'h01))
      else $error("reference jumped more than one step");
   a_pg_masked: assert property (@(posedge clk) disable iff (srst)
      st_q == vrs_pkg::VRS_ST_STEP |=> !pg_q)
      else $error("power-good active during step");
   a_fault_latch: assert property (@(posedge clk) disable iff (srst)
      fault_q |=> fault_q && !osc_inhibit_fault_pin_oe_n)
      else $error("fault cleared");
   a_ov_crowbar: assert property (@(posedge clk) disable iff (srst)
      fault_q && ov_q |=> gate_q.ls1 && gate_q.ls2 && !gate_q.hs1)
      else $error("crowbar not applied");
   a_off_drives: assert property (@(posedge clk) disable iff (srst)
      no_load_shutdown_mode |=> gate_q == '0)
      else $error("drives on in shutdown");
   a_phase_apart: assert property (@(posedge clk) disable iff (srst)
      !(gate_q.hs1 && gate_q.hs2))
      else $error("both high sides on");
   a_tgt_hold: assert property (@(posedge clk) disable iff (srst)
      st_q == vrs_pkg::VRS_ST_STEP && $past(st_q) == vrs_pkg::VRS_ST_STEP
      |-> $stable(tgt_q))
      else $error("target changed mid step");
   a_inh_off: assert property (@(posedge clk) disable iff (srst)
      inhibit && !fault_q |=> gate_q == '0)
      else $error("drives on in inhibit");
   // reference only moves on a switching tick
   a_tick_paced: assert property (@(posedge clk) disable iff (srst)
      !sw_tick |=> $stable(ref_q))
      else $error("reference moved between ticks");
   // target only taken from a settled code
   a_take_stable: assert property (@(posedge clk) disable iff (srst)
      sw_tick && st_q == vrs_pkg::VRS_ST_RUN &&
      stab_q != vrs_pkg::VRS_STABLE_CNT |=> $stable(tgt_q))
      else $error("unsettled code taken as target");
   // power-good pulled low outside the window
   a_pg_window: assert property (@(posedge clk) disable iff (srst)
      !pg_in |=> !power_good_output_oe_n)
      else $error("power-good released outside window");
   a_inh_freeze: assert property (@(posedge clk) disable iff (srst)
      inhibit |=> $stable(st_q) && $stable(ref_q))
      else $error("sequencer moved in inhibit");
   // shutdown stays latched with protections off
   a_off_latch: assert property (@(posedge clk) disable iff (srst)
      no_load_shutdown_mode |=> no_load_shutdown_mode && !fault_q)
      else $error("shutdown not held");
endmodule // vrs_sequencer

// >>> rtl/vrs_pkg.sv
// package: constants and carrier types for the reference sequencer
package vrs_pkg;
   // code width and reserved shutdown code
   localparam int unsigned          VRS_CODE_W      = 5;
   localparam logic [4:0]           VRS_CODE_OFF    = 5'h1f;
   localparam logic [4:0]           VRS_CODE_RST    = 5'h1f;
   // reference scale in millivolts
   localparam int unsigned          VRS_REF_TOP_MV  = 1550;
   localparam int unsigned          VRS_STEP_MV     = 25;
   localparam int unsigned          VRS_REF_BOT_MV  = 800;
   // switching clock: 200 kHz derived from 250 MHz system clock
   localparam int unsigned          VRS_CLK_HZ      = 250_000_000;
   localparam int unsigned          VRS_SW_HZ       = 200_000;
   localparam int unsigned          VRS_SW_DIV      = VRS_CLK_HZ / VRS_SW_HZ;
   // stability: code must hold for more than one switching cycle
   localparam logic [1:0]           VRS_STABLE_CNT  = 2'h2;
   // APB register byte offsets
   localparam logic [7:0]           VRS_OFF_CTRL    = 8'h00;
   localparam logic [7:0]           VRS_OFF_STAT    = 8'h04;
   localparam logic [7:0]           VRS_OFF_IRQ_ST  = 8'h08;
   localparam logic [7:0]           VRS_OFF_IRQ_EN  = 8'h0c;
   localparam logic [7:0]           VRS_OFF_IRQ_CLR = 8'h10;
   localparam logic [7:0]           VRS_OFF_SENSE   = 8'h14;
   // control register reset: run enabled
   localparam logic [31:0]          VRS_CTRL_RST    = 32'h0000_0001;
   // window and protection margins around the reference, in mV
   localparam int unsigned          VRS_PG_MARGIN   = 100;
   localparam int unsigned          VRS_OV_MARGIN   = 250;
   localparam int unsigned          VRS_UV_MARGIN   = 300;
   // interrupt bit positions
   localparam int unsigned          VRS_IRQ_DONE    = 0;
   localparam int unsigned          VRS_IRQ_OV      = 1;
   localparam int unsigned          VRS_IRQ_UV      = 2;
   localparam int unsigned          VRS_IRQ_OFF     = 3;
   localparam int unsigned          VRS_IRQ_INH     = 4;
   localparam int unsigned          VRS_IRQ_W       = 5;

   // sequencer states
   typedef enum logic [3:0] {
      VRS_ST_RUN  = 4'b0001,
      VRS_ST_STEP = 4'b0010,
      VRS_ST_OFF  = 4'b0100,
      VRS_ST_FLT  = 4'b1000
   } vrs_state_t;

   // gate drive carrier for both phases
   typedef struct packed {
      logic hs1;
      logic ls1;
      logic hs2;
      logic ls2;
   } vrs_gate_t;

   // reference in millivolts for a code
   function automatic logic [11:0] vrs_code_mv(input logic [4:0] code);
      vrs_code_mv = 12'(VRS_REF_TOP_MV) - 12'(code) * 12'(VRS_STEP_MV);
   endfunction
endpackage

// >>> verification/vrs_far_side.sv
// far-side model: identification straps, power stage sense, inhibit pin
module vrs_far_side (
   // bench knobs
   input  wire logic [4:0]         strap_code,
   input  wire logic               inhibit_hold,
   input  wire logic signed [12:0] sense_offset,
   // device side
   input  wire logic [4:0]         programmed_reference,
   input  wire logic               pin_o,
   input  wire logic               pin_oe_n,
   output logic      [4:0]         voltage_id_inputs,
   output logic      [11:0]        sense_mv,
   output logic                    pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // ========================================
   // straps and power stage
   // grounded strap reads zero, floating strap pulls up to one
   assign voltage_id_inputs = strap_code;
   // output follows the reference; offset models a load or stage fault
   assign sense_mv = 12'(int'(vrs_pkg::VRS_REF_TOP_MV)
      - int'(vrs_pkg::VRS_STEP_MV) * int'(programmed_reference)
      + int'(sense_offset));
   // released pin idles high; holding it low requests inhibit
   assign pin_level = !pin_oe_n ? pin_o : !inhibit_hold;
endmodule // vrs_far_side

// >>> verification/vrs_sequencer_tb.sv
// self-checking bench for the reference sequencer
module vrs_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned SW = 8;
   typedef struct {
      logic [4:0] code;
      int         off;
      logic [4:0] ref_e;
      logic       pg_e;
   } vrs_row_t;
   // ========================================
   // signals
   logic               clk, srst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic               pin_o, pin_oe_n, pin_lvl, pg_o, pg_oe_n;
   logic [4:0]         vid, strap, pref, prev;
   logic [11:0]        sense;
   logic signed [12:0] offs;
   logic               inh, lsd1, lsd2, nols, irq, step_on;
   vrs_pkg::vrs_gate_t gate;
   int                 n_mismatch, compares, i;
   vrs_row_t           rows [6] = '{'{5'h0a, 0, 5'h0a, 1},
      '{5'h00, 0, 5'h00, 1}, '{5'h1e, 0, 5'h1e, 1},
      '{5'h0c, 150, 5'h0c, 0}, '{5'h0c, -150, 5'h0c, 0},
      '{5'h0c, 60, 5'h0c, 1}};
   vrs_sequencer #(.SW_DIV(SW)) dut (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .voltage_id_inputs(vid), .sense_mv(sense),
      .osc_inhibit_fault_pin_i(pin_lvl), .osc_inhibit_fault_pin_o(pin_o),
      .osc_inhibit_fault_pin_oe_n(pin_oe_n), .power_good_output_o(pg_o),
      .power_good_output_oe_n(pg_oe_n), .programmed_reference(pref),
      .gate(gate), .phase1_low_side_drive(lsd1),
      .phase2_low_side_drive(lsd2), .no_load_shutdown_mode(nols),
      .irq(irq));
   vrs_far_side far (.strap_code(strap), .inhibit_hold(inh),
      .sense_offset(offs), .programmed_reference(pref), .pin_o(pin_o),
      .pin_oe_n(pin_oe_n), .voltage_id_inputs(vid), .sense_mv(sense),
      .pin_level(pin_lvl));
   // ========================================
   // clock, tasks, monitors
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_ref(input logic [4:0] e);
      for (int k = 0; k < 600 && pref !== e; k++) @(posedge clk);
      chk(pref, e);
   endtask
   task automatic do_reset;
      step_on <= 1'b0;
      srst <= 1'b1;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic summarize;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // a hung wait must not stall the run forever
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize;
   end
   // once started, reference moves one code at a time
   always @(posedge clk) begin
      prev <= pref;
      if (step_on && pref !== prev)
         chk(pref > prev ? pref - prev : prev - pref, 1);
   end
   // ========================================
   // main sequence
   initial begin
      {srst, psel, penable, pwrite, inh, step_on} = 6'b10_0000;
      paddr = '0;
      pwdata = '0;
      strap = 5'h0a;
      offs = '0;
      do_reset;
      for (i = 0; i < 6; i++) begin
         strap <= rows[i].code;
         offs <= 13'(rows[i].off);
         wait_ref(rows[i].ref_e);
         repeat (4 * SW) @(posedge clk);
         chk({pg_o, pg_oe_n}, {1'b0, rows[i].pg_e});
         step_on <= 1'b1;
      end
      offs <= '0;
      apb(1, vrs_pkg::VRS_OFF_IRQ_CLR, 32'h0000_001f, rd);
      apb(1, vrs_pkg::VRS_OFF_IRQ_EN, 32'h0000_0001, rd);
      strap <= 5'h00;
      for (i = 0; i < 200 && pref === 5'h0c; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk(pg_oe_n, 1'b0);
      strap <= 5'h05;
      wait_ref(5'h00);
      wait_ref(5'h05);
      repeat (4 * SW) @(posedge clk);
      chk(irq, 1'b1);
      apb(0, vrs_pkg::VRS_OFF_IRQ_ST, '0, rd);
      chk(rd[0], 1'b1);
      apb(1, vrs_pkg::VRS_OFF_IRQ_CLR, 32'h0000_0001, rd);
      chk(irq, 1'b0);
      apb(1, vrs_pkg::VRS_OFF_IRQ_EN, 32'h0000_0000, rd);
      strap <= 5'h06;
      wait_ref(5'h06);
      repeat (4 * SW) @(posedge clk);
      chk(irq, 1'b0);
      apb(0, vrs_pkg::VRS_OFF_IRQ_ST, '0, rd);
      chk(rd[0], 1'b1);
      apb(0, 8'h18, '0, rd);
      chk(rd, 32'h0000_0000);
      chk(pslverr, 1'b0);
      // single-tick glitch must not be taken
      strap <= 5'h09;
      repeat (6) @(posedge clk);
      strap <= 5'h06;
      repeat (6 * SW) @(posedge clk);
      chk(pref, 5'h06);
      // settled at code 6: run state, target and reference 6, power good
      apb(0, vrs_pkg::VRS_OFF_STAT, '0, rd);
      chk(rd, 32'h0000_131a);
      // stage follows the reference: 1550 mV minus six steps
      apb(0, vrs_pkg::VRS_OFF_SENSE, '0, rd);
      chk(rd, 32'h0000_0578);
      inh <= 1'b1;
      repeat (3 * SW) @(posedge clk);
      chk(gate, 4'h0);
      apb(0, vrs_pkg::VRS_OFF_IRQ_ST, '0, rd);
      chk(rd[4], 1'b1);
      strap <= 5'h08;
      repeat (6 * SW) @(posedge clk);
      chk(pref, 5'h06);
      inh <= 1'b0;
      wait_ref(5'h08);
      offs <= 13'sd400;
      for (i = 0; i < 10 * SW && pin_oe_n !== 1'b0; i++) @(posedge clk);
      // crowbar reaches the registered drives one edge after the latch
      repeat (2) @(posedge clk);
      chk(pin_lvl, 1'b1);
      chk({lsd1, lsd2, gate.hs1, gate.hs2}, 4'b1100);
      apb(0, vrs_pkg::VRS_OFF_IRQ_ST, '0, rd);
      chk(rd[1], 1'b1);
      offs <= '0;
      repeat (6 * SW) @(posedge clk);
      chk(pin_oe_n, 1'b0);
      strap <= 5'h14;
      do_reset;
      chk({pin_oe_n, pref}, 6'h3f);
      apb(0, vrs_pkg::VRS_OFF_CTRL, '0, rd);
      chk(rd, vrs_pkg::VRS_CTRL_RST);
      wait_ref(5'h14);
      offs <= -13'sd400;
      for (i = 0; i < 10 * SW && pin_oe_n !== 1'b0; i++) @(posedge clk);
      chk(pin_lvl, 1'b1);
      apb(0, vrs_pkg::VRS_OFF_IRQ_ST, '0, rd);
      chk(rd[2], 1'b1);
      strap <= 5'h1f;
      do_reset;
      for (i = 0; i < 10 * SW && nols !== 1'b1; i++) @(posedge clk);
      chk({nols, gate}, 5'h10);
      strap <= 5'h04;
      offs <= 13'sd400;
      repeat (8 * SW) @(posedge clk);
      chk({nols, pin_oe_n}, 2'b11);
      summarize;
   end
endmodule // vrs_sequencer_tb
